// File: rtl/tpg_consts.vh
// Summary of operation
// R1: Port A direction one means input, zero drives
// R2: Port A reads pins, writes load latch
// R3: Analog field selects analog pins, reset analog
// R4: Port A bit 4 open-drain, feeds timer clock
// R5: Port A bit 5 feeds serial slave select
// R6: Unimplemented port A bits read zero
// R7: Port B eight pins, direction one is input
// R8: Clear option bit 7 enables port B pull-ups
// R9: Output pins never get a pull-up
// R10: Option resets all ones, pull-ups off
// R11: Only upper four input pins sense change
// R12: Mismatch against last-read copy sets flag
// R13: Port change condition wakes from sleep
// R14: Mismatch keeps setting flag until copy refreshed
// R15: Software avoids polling port B during sensing
// R16: Port B bit 0 edge interrupt, edge selectable
// R17: Port C eight pins, direction one is input
// R18: Peripheral may force port C pin direction
// R19: Select picks latch or peripheral data, enable
// R20: Software avoids bit updates of port C direction
// R21: Port B/C read pins, writes load latches
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH

// ============================================================
// Register offsets
`define TPG_ADDR_PORT_A 8'h05
`define TPG_ADDR_PORT_B 8'h06
`define TPG_ADDR_PORT_C 8'h07
`define TPG_ADDR_INTCTL 8'h0b
`define TPG_ADDR_OPTION 8'h81
`define TPG_ADDR_DIR_A 8'h85
`define TPG_ADDR_DIR_B 8'h86
`define TPG_ADDR_DIR_C 8'h87
`define TPG_ADDR_ANALOG 8'h9f

// ============================================================
// Reset values
`define TPG_RST_OPTION 8'hff
`define TPG_RST_DIR_A 6'h3f
`define TPG_RST_DIR_B 8'hff
`define TPG_RST_DIR_C 8'hff
`define TPG_RST_ANALOG 3'h0
`define TPG_RST_INTCTL 8'h00
`define TPG_RST_LATCH 8'h00
`define TPG_RST_LATCH_A 6'h00
`define TPG_RST_COPY 4'h0

// ============================================================
// Field positions
`define TPG_OPT_PULLUP_N 7
`define TPG_OPT_EDGE_SEL 6
`define TPG_INT_CHANGE 0
`define TPG_INT_EXT 1
`define TPG_PA_TIMER 4
`define TPG_PA_SELECT 5

`endif

// File: rtl/tpg_gpio.v
`timescale 1ns/100ps
`include "tpg_consts.vh"

module tpg_gpio
(
    // Clock and reset
    input wire i_ref_clk,
    input wire i_reset,
    // Register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Port A pins
    input wire [5:0] i_port_a_pin,
    output reg [5:0] o_port_a_out,
    output reg [5:0] o_port_a_oe,
    // Port B pins
    input wire [7:0] i_port_b_pin,
    output reg [7:0] o_port_b_out,
    output reg [7:0] o_port_b_oe,
    output reg [7:0] o_port_b_pullup,
    // Port C pins
    input wire [7:0] i_port_c_pin,
    output reg [7:0] o_port_c_out,
    output reg [7:0] o_port_c_oe,
    // Port C peripheral controls, same clock
    input wire [7:0] i_periph_sel,
    input wire [7:0] i_periph_out,
    input wire [7:0] i_periph_oe,
    input wire [7:0] i_periph_dir_ovr,
    input wire [7:0] i_periph_dir_in,
    // Peripheral and core taps
    output reg o_timer_clock_in,
    output reg o_slave_select_n,
    output reg [7:0] o_port_c_in,
    output reg [4:0] o_analog_mask,
    output reg o_port_change_flag,
    output reg o_ext_irq_flag,
    output reg o_wake
);

    // ============================================================
    // Pin synchronisers
    // Resetting the stages keeps read data defined right after reset
    // Cost: two cycles of lag on every pin read and change event
    // Only the second stage of each pair feeds any logic
    reg [5:0] sync_a_0; // First stage, read only by second
    reg [5:0] sync_a;
    // Port B stages feed change and edge logic
    reg [7:0] sync_b_0;
    reg [7:0] sync_b;
    // Port C stages feed reads and the input tap
    reg [7:0] sync_c_0;
    reg [7:0] sync_c;

    // Two flops per pin; pins are asynchronous to the core
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            sync_a_0 <= 6'h00;
            sync_a <= 6'h00;
            sync_b_0 <= 8'h00;
            sync_b <= 8'h00;
            sync_c_0 <= 8'h00;
            sync_c <= 8'h00;
        end
        else
        begin
            sync_a_0 <= i_port_a_pin;
            sync_a <= sync_a_0;
            sync_b_0 <= i_port_b_pin;
            sync_b <= sync_b_0;
            sync_c_0 <= i_port_c_pin;
            sync_c <= sync_c_0;
        end
    end

    // ============================================================
    // Register storage
    // Latches hold what software wrote; pins may show something else
    // Bits 7:2 of the interrupt register are plain storage
    reg [5:0] port_a_latch; // Output latch A
    reg [7:0] port_b_latch; // Output latch B
    reg [7:0] port_c_latch; // Output latch C
    reg [5:0] port_a_direction; // One means input
    reg [7:0] port_b_direction;
    reg [7:0] port_c_direction;
    reg [7:0] option_control; // Pull-up and edge controls
    reg [2:0] analog_config_field; // Analog pin selection
    reg [7:0] interrupt_control; // Flags in bits 1:0
    reg [3:0] change_copy; // Last-read upper port B
    reg ext_prev; // Previous port B bit 0 level

    // Decoded strobes used only by the register write process
    wire wr_a = i_wr && (i_addr == `TPG_ADDR_PORT_A);
    wire wr_b = i_wr && (i_addr == `TPG_ADDR_PORT_B);
    wire rd_b = i_rd && (i_addr == `TPG_ADDR_PORT_B);
    wire wr_int = i_wr && (i_addr == `TPG_ADDR_INTCTL);

    // ============================================================
    // Analog pin map
    reg [4:0] analog_mask; // Bits: A5, A3..A0

    // Bit 4 has no analog use, so the mask skips it
    // Reset code is zero, so every analog pin starts analog
    // Field 0 all analog; 11x all digital; else A3, A1, A0 analog
    // Unlisted codes fall in the mixed group on purpose
    always @*
    begin
        if (analog_config_field == 3'h0)
            analog_mask = 5'h1f; // [R3]
        else if (analog_config_field[2:1] == 2'h3)
            analog_mask = 5'h00;
        else
            analog_mask = 5'h0b;
    end

    // Digital view of port A: analog pins read zero
    // Mask order: A5, A3, A2, A1, A0; A4 stays digital
    wire [5:0] analog_a = {analog_mask[4], 1'b0, analog_mask[3:0]};
    wire [5:0] port_a_digital = sync_a & ~analog_a; // [R3]

    // ============================================================
    // Port C effective direction
    wire [7:0] eff_dir_c; // One means input

    // Peripheral override wins over the stored direction
    // A peripheral with no override leaves the stored bit in charge
    assign eff_dir_c = (i_periph_dir_ovr & i_periph_dir_in) |
        (~i_periph_dir_ovr & port_c_direction); // [R18]

    // ============================================================
    // Change detection and external edge
    // Only upper input pins that differ from the copy count
    // Output pins are masked so their own drive cannot trip it
    // Copy resets to zero; a high upper pin flags until read
    // A read or write of port B refreshes the copy and ends it
    wire [3:0] change_diff = (sync_b[7:4] ^ change_copy) &
        port_b_direction[7:4]; // [R11]
    wire mismatch = |change_diff; // [R12]
    // One-cycle pulse on the chosen edge of the synced bit 0
    wire ext_edge = option_control[`TPG_OPT_EDGE_SEL] ?
        (sync_b[0] && !ext_prev) : (!sync_b[0] && ext_prev); // [R16]

    // ============================================================
    // Register writes and hardware-set flags
    // All software-writable state lives here, in one clocked process
    // Unmapped addresses fall through every test and change nothing
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            port_a_latch <= `TPG_RST_LATCH_A;
            port_b_latch <= `TPG_RST_LATCH;
            port_c_latch <= `TPG_RST_LATCH;
            port_a_direction <= `TPG_RST_DIR_A;
            port_b_direction <= `TPG_RST_DIR_B;
            port_c_direction <= `TPG_RST_DIR_C;
            option_control <= `TPG_RST_OPTION; // [R10]
            analog_config_field <= `TPG_RST_ANALOG; // [R3]
            interrupt_control <= `TPG_RST_INTCTL;
            change_copy <= `TPG_RST_COPY;
            ext_prev <= 1'b0;
        end
        else
        begin
            // Edge history for the external interrupt input
            ext_prev <= sync_b[0];
            // Whole-byte stores; software merges bits before writing
            if (wr_a)
                port_a_latch <= i_wdata[5:0]; // [R2]
            if (wr_b)
                port_b_latch <= i_wdata; // [R21]
            if (i_wr && (i_addr == `TPG_ADDR_PORT_C))
                port_c_latch <= i_wdata; // [R21]
            // Port A keeps six bits; the top two are not stored
            if (i_wr && (i_addr == `TPG_ADDR_DIR_A))
                port_a_direction <= i_wdata[5:0];
            if (i_wr && (i_addr == `TPG_ADDR_DIR_B))
                port_b_direction <= i_wdata;
            // Stored bits only; overrides never get written back
            if (i_wr && (i_addr == `TPG_ADDR_DIR_C))
                port_c_direction <= i_wdata; // [R20]
            if (i_wr && (i_addr == `TPG_ADDR_OPTION))
                option_control <= i_wdata;
            if (i_wr && (i_addr == `TPG_ADDR_ANALOG))
                analog_config_field <= i_wdata[2:0];
            // Any port B access refreshes the comparison copy
            if (rd_b || wr_b)
                change_copy <= sync_b[7:4]; // [R14] [R15]
            // Flag bits: the hardware set wins over a software clear
            interrupt_control[7:2] <= wr_int ? i_wdata[7:2] :
                interrupt_control[7:2];
            interrupt_control[`TPG_INT_CHANGE] <= mismatch ||
                (wr_int ? i_wdata[`TPG_INT_CHANGE] :
                interrupt_control[`TPG_INT_CHANGE]); // [R12] [R14]
            interrupt_control[`TPG_INT_EXT] <= ext_edge ||
                (wr_int ? i_wdata[`TPG_INT_EXT] :
                interrupt_control[`TPG_INT_EXT]); // [R16]
        end
    end

    // ============================================================
    // Read data, one cycle after the strobe
    // Decode is combinational; the port only latches it on a read
    // Reads have no side effect here except the port B copy refresh
    reg [7:0] next_rdata;

    always @*
    begin
        next_rdata = 8'h00;
        case (i_addr)
            `TPG_ADDR_PORT_A: next_rdata = {2'h0, port_a_digital}; // [R6]
            // Port reads return pins, never latches
            `TPG_ADDR_PORT_B: next_rdata = sync_b; // [R21]
            `TPG_ADDR_PORT_C: next_rdata = sync_c; // [R21]
            `TPG_ADDR_INTCTL: next_rdata = interrupt_control;
            `TPG_ADDR_OPTION: next_rdata = option_control;
            `TPG_ADDR_DIR_A: next_rdata = {2'h0, port_a_direction}; // [R6]
            `TPG_ADDR_DIR_B: next_rdata = port_b_direction;
            // Shows the direction after peripheral overrides, not what was stored
            `TPG_ADDR_DIR_C: next_rdata = eff_dir_c; // [R20]
            `TPG_ADDR_ANALOG: next_rdata = {5'h00, analog_config_field};
            default: next_rdata = 8'h00; // Unmapped reads as zero
        endcase
    end

    // Zero outside the read slot, so a stale value never lingers
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= 8'h00;
    end

    // ============================================================
    // Pin drivers for ports A and B
    reg [5:0] next_a_out;
    reg [5:0] next_a_oe;

    // Port A: direction one tri-states; bit 4 may only sink
    // Open drain: a one on bit 4 releases the pin to the board
    always @*
    begin
        next_a_out = port_a_latch;
        next_a_oe = ~port_a_direction; // [R1]
        next_a_out[`TPG_PA_TIMER] = 1'b0;
        next_a_oe[`TPG_PA_TIMER] = !port_a_direction[`TPG_PA_TIMER] &&
            !port_a_latch[`TPG_PA_TIMER]; // [R4]
    end

    // Registered so every pin control comes straight from a flop
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_port_a_out <= 6'h00;
            o_port_a_oe <= 6'h00;
            o_port_b_out <= 8'h00;
            o_port_b_oe <= 8'h00;
            o_port_b_pullup <= 8'h00;
        end
        else
        begin
            o_port_a_out <= next_a_out;
            o_port_a_oe <= next_a_oe;
            // Port B drives its latch wherever direction is zero
            o_port_b_out <= port_b_latch;
            o_port_b_oe <= ~port_b_direction; // [R7]
            // Pull-ups only on input pins, all under one control bit
            // Pull-ups follow the direction bits with one cycle of lag
            o_port_b_pullup <= port_b_direction &
                {8{~option_control[`TPG_OPT_PULLUP_N]}}; // [R8] [R9]
        end
    end

    // ============================================================
    // Port C per-pin driver
    // Each bit has its own select, so the loop keeps them apart
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_port_c
            // Peripheral enable counts only while its select is on
            always @(posedge i_ref_clk)
            begin
                if (i_reset)
                begin
                    // Reset leaves every port C pin released
                    o_port_c_out[gi] <= 1'b0;
                    o_port_c_oe[gi] <= 1'b0;
                end
                else
                begin
                    // Peripheral data only while its select is on
                    o_port_c_out[gi] <= i_periph_sel[gi] ?
                        i_periph_out[gi] : port_c_latch[gi]; // [R19]
                    o_port_c_oe[gi] <= !eff_dir_c[gi] ||
                        (i_periph_sel[gi] && i_periph_oe[gi]); // [R17] [R19]
                end
            end
        end
    endgenerate

    // ============================================================
    // Taps to peripherals and core
    // Peripheral taps are the synced pins, one more flop behind
    // Wake follows the live mismatch, not the flag, so it drops
    // as soon as the copy is refreshed
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_timer_clock_in <= 1'b0;
            // Select stays high in reset, so the serial port is idle
            o_slave_select_n <= 1'b1;
            o_port_c_in <= 8'h00;
            o_analog_mask <= 5'h1f;
            o_port_change_flag <= 1'b0;
            o_ext_irq_flag <= 1'b0;
            o_wake <= 1'b0;
        end
        else
        begin
            o_timer_clock_in <= sync_a[`TPG_PA_TIMER]; // [R4]
            o_slave_select_n <= sync_a[`TPG_PA_SELECT]; // [R5]
            o_port_c_in <= sync_c;
            o_analog_mask <= analog_mask; // [R3]
            // Flags are copies of the register bits, one cycle behind
            o_port_change_flag <= interrupt_control[`TPG_INT_CHANGE];
            o_ext_irq_flag <= interrupt_control[`TPG_INT_EXT];
            o_wake <= mismatch; // [R13]
        end
    end

endmodule // tpg_gpio

// File: tb/three_port_gpio_tb.sv
`timescale 1ns/100ps
// ========================================
// Self-checking bench for the GPIO block
module three_port_gpio_tb;
    reg clk, rst, wr, rd;
    reg [7:0] addr, wdata, psel, pout, poe, povr, pdin, eb, eben, ec;
    reg [5:0] ea, ea_pull, ea_en;
    reg [7:0] ec_pull, ec_en;
    reg [7:0] d_a, d_b, d_c, l_a, l_b, l_c, ka, kc, eff, c_dr, c_v;
    wire [7:0] rdata, pb, b_out, b_oe, b_pull, pc, c_out, c_oe, c_in;
    wire [5:0] pa, a_out, a_oe;
    wire [4:0] amask;
    wire tmr, ssn, chg, xirq, wake;
    integer fails, cmp_count, i;
    // ========================================
    // Block and board
    tpg_gpio dut_u
    (
        .i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_port_a_pin(pa),
        .o_port_a_out(a_out), .o_port_a_oe(a_oe), .i_port_b_pin(pb),
        .o_port_b_out(b_out), .o_port_b_oe(b_oe), .o_port_b_pullup(b_pull),
        .i_port_c_pin(pc), .o_port_c_out(c_out), .o_port_c_oe(c_oe),
        .i_periph_sel(psel), .i_periph_out(pout), .i_periph_oe(poe),
        .i_periph_dir_ovr(povr), .i_periph_dir_in(pdin),
        .o_timer_clock_in(tmr), .o_slave_select_n(ssn), .o_port_c_in(c_in),
        .o_analog_mask(amask), .o_port_change_flag(chg),
        .o_ext_irq_flag(xirq), .o_wake(wake)
    );
    tpg_pin_model #(.W(6)) pins_a_u (.i_ref_clk(clk), .i_oe(a_oe),
        .i_out(a_out), .i_pull(ea_pull), .i_ext_en(ea_en), .i_ext_val(ea),
        .o_level(pa));
    tpg_pin_model #(.W(8)) pins_b_u (.i_ref_clk(clk), .i_oe(b_oe),
        .i_out(b_out), .i_pull(b_pull), .i_ext_en(eben), .i_ext_val(eb),
        .o_level(pb));
    tpg_pin_model #(.W(8)) pins_c_u (.i_ref_clk(clk), .i_oe(c_oe),
        .i_out(c_out), .i_pull(ec_pull), .i_ext_en(ec_en), .i_ext_val(ec),
        .o_level(pc));
    // ========================================
    // Helpers
    function [7:0] pin_lvl(input [7:0] dir, input [7:0] lat,
        input [7:0] ext);
        pin_lvl = (dir & ext) | (~dir & lat);
    endfunction
    task chk(input [7:0] g, input [7:0] e);
    begin
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    end
    endtask
    task tick(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
    begin
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    end
    endtask
    task rreg(input [7:0] a, input [7:0] e);
    begin
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clk);
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // ========================================
    // Clock and watchdog
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #60000;
        fails = fails + 1;
        report_and_stop;
    end
    // ========================================
    // Main sequence
    initial
    begin
        {fails, cmp_count} = 64'h0;
        {rst, wr, rd, addr, wdata} = {1'b1, 18'h0};
        {psel, pout, poe, povr, pdin, eb, ec, l_b} = 64'h0;
        {eben, ea} = 14'h3fff;
        {ea_pull, ec_pull, ea_en, ec_en} = 28'h0003fff;
        void'($urandom(26));
        tick(2);
        rst <= 1'b0;
        tick(1);
        rreg(8'h81, 8'hff);
        rreg(8'h85, 8'h3f);
        rreg(8'h86, 8'hff);
        rreg(8'h87, 8'hff);
        rreg(8'h9f, 8'h00);
        rreg(8'h05, 8'h10);
        rreg(8'h55, 8'h00);
        chk(b_pull, 8'h00);
        chk({3'h0, amask}, 8'h1f);
        wreg(8'h9f, 8'h06);
        tick(2);
        chk({3'h0, amask}, 8'h00);
        $display("test reset done");
        for (i = 0; i < 24; i = i + 1)
        begin
            {d_a, l_a, d_b, l_b} = $urandom;
            {d_c, l_c} = 16'($urandom);
            {psel, pout, poe, povr} <= $urandom;
            {pdin, ec, eb, ea} <= 30'($urandom);
            wreg(8'h85, d_a);
            wreg(8'h05, l_a);
            wreg(8'h86, d_b);
            wreg(8'h06, l_b);
            wreg(8'h87, d_c); // Whole byte only
            wreg(8'h07, l_c);
            tick(4);
            eff = (povr & pdin) | (~povr & d_c);
            c_dr = ~eff | (psel & poe);
            c_v = (psel & pout) | (~psel & l_c);
            ka = pin_lvl(d_a | 8'h10, l_a, {2'h0, ea})
                & ~(~d_a & ~l_a & 8'h10) & 8'h3f;
            kc = pin_lvl(~c_dr, c_v, ec);
            chk({2'h0, a_oe}, ~d_a & ~(l_a & 8'h10) & 8'h3f);
            chk(b_oe, ~d_b);
            chk(c_oe, c_dr);
            chk(c_out, c_v);
            chk({6'h0, ssn, tmr}, {6'h0, ka[5:4]});
            rreg(8'h85, d_a & 8'h3f);
            rreg(8'h05, ka);
            rreg(8'h06, pin_lvl(d_b, l_b, eb));
            rreg(8'h07, kc);
            rreg(8'h87, eff);
            chk(c_in, kc);
        end
        $display("test random done");
        eben <= 8'h00;
        wreg(8'h86, 8'hf0);
        wreg(8'h81, 8'h7f);
        tick(4);
        chk(b_pull, 8'hf0);
        rreg(8'h06, {4'hf, l_b[3:0]});
        wreg(8'h81, 8'hff);
        tick(1);
        chk(b_pull, 8'h00);
        $display("test pull-up done");
        {eben, eb} <= 16'hff00;
        wreg(8'h06, 8'h80);
        wreg(8'h86, 8'h7f);
        tick(4);
        rreg(8'h06, 8'h80);
        wreg(8'h0b, 8'h00);
        eb <= 8'h08;
        tick(5);
        chk({6'h0, chg, wake}, 8'h00);
        eb <= 8'h48;
        tick(5);
        chk({6'h0, chg, wake}, 8'h03);
        wreg(8'h0b, 8'h00);
        tick(2);
        chk({7'h0, chg}, 8'h01);
        rreg(8'h06, 8'hc8); // One read, no polling
        tick(2);
        wreg(8'h0b, 8'h00);
        tick(2);
        chk({6'h0, chg, wake}, 8'h00);
        $display("test change done");
        eb <= 8'h49;
        tick(5);
        chk({7'h0, xirq}, 8'h01);
        wreg(8'h81, 8'hbf);
        wreg(8'h0b, 8'h00);
        eb <= 8'h48;
        tick(5);
        chk({7'h0, xirq}, 8'h01);
        wreg(8'h0b, 8'h00);
        eb <= 8'h49;
        tick(5);
        chk({7'h0, xirq}, 8'h00);
        $display("test edge done");
        {psel, povr, ea_en, ec_en} <= 30'h0;
        {ea_pull, ec_pull} <= 14'h3fff;
        wreg(8'h85, 8'h3f);
        wreg(8'h87, 8'hff);
        tick(4);
        rreg(8'h05, 8'h3f);
        rreg(8'h07, 8'hff);
        $display("test release done");
        report_and_stop;
    end
endmodule // three_port_gpio_tb

// File: tb/tpg_gpio_properties.sv
`timescale 1ns/100ps
// ========================================
// Port-level checks on the GPIO block
module tpg_gpio_properties
(
    // Clock, reset and register port
    input wire i_ref_clk,
    input wire i_reset,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Pin drivers
    input wire [5:0] o_port_a_out,
    input wire [7:0] o_port_b_oe,
    input wire [7:0] o_port_b_pullup,
    input wire [7:0] o_port_c_out,
    input wire [7:0] o_port_c_oe,
    // Peripheral controls
    input wire [7:0] i_periph_sel,
    input wire [7:0] i_periph_out,
    input wire [7:0] i_periph_oe,
    input wire [7:0] i_periph_dir_ovr,
    input wire [7:0] i_periph_dir_in,
    // Status taps
    input wire [4:0] o_analog_mask,
    input wire o_port_change_flag,
    input wire o_wake
);
    reg [7:0] p_sel, p_out, p_outf, p_inf; // Peripheral inputs, one cycle old
    // Delayed copies line up with the block's one-cycle output lag
    always @(posedge i_ref_clk)
    begin
        p_sel <= i_periph_sel;
        p_out <= i_periph_out;
        p_outf <= (i_periph_dir_ovr & ~i_periph_dir_in)
            | (i_periph_sel & i_periph_oe);
        p_inf <= i_periph_dir_ovr & i_periph_dir_in
            & ~(i_periph_sel & i_periph_oe);
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    a_dir_b_oe: assert property (i_wr && i_addr == 8'h86
        |-> ##2 o_port_b_oe == ~$past(i_wdata, 2)) else $error("b enable");
    a_pull_output: assert property ((o_port_b_pullup & o_port_b_oe)
        == 8'h00) else $error("pull-up on output");
    a_pull_off: assert property (i_wr && i_addr == 8'h81 && i_wdata[7]
        |-> ##2 o_port_b_pullup == 8'h00) else $error("pull-up not off");
    a_open_drain: assert property (o_port_a_out[4] == 1'b0)
        else $error("bit4 drives high");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside slot");
    a_a_upper_zero: assert property ($past(i_rd)
        && ($past(i_addr) & 8'h7f) == 8'h05 |-> o_rdata[7:6] == 2'b00)
        else $error("upper port A bits set");
    a_c_data_sel: assert property (!$past(i_reset)
        |-> (p_sel & (p_out ^ o_port_c_out)) == 8'h00) else $error("c data");
    a_c_force_out: assert property (!$past(i_reset)
        |-> (p_outf & ~o_port_c_oe) == 8'h00) else $error("c not driven");
    a_c_force_in: assert property (!$past(i_reset)
        |-> (p_inf & o_port_c_oe) == 8'h00) else $error("c not released");
    a_wake_flag: assert property ($rose(o_wake)
        |=> o_port_change_flag) else $error("change flag missing");
    a_analog_reset: assert property ($fell(i_reset)
        |-> o_analog_mask == 5'h1f) else $error("analog reset");
    cover property ($rose(o_port_change_flag));
    cover property (o_port_b_pullup == 8'hf0);
    cover property (p_sel != 8'h00 && o_port_c_oe != 8'h00);
endmodule // tpg_gpio_properties

bind tpg_gpio tpg_gpio_properties chk_u
(
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_port_a_out(o_port_a_out), .o_port_b_oe(o_port_b_oe),
    .o_port_b_pullup(o_port_b_pullup), .o_port_c_out(o_port_c_out),
    .o_port_c_oe(o_port_c_oe), .i_periph_sel(i_periph_sel),
    .i_periph_out(i_periph_out), .i_periph_oe(i_periph_oe),
    .i_periph_dir_ovr(i_periph_dir_ovr), .i_periph_dir_in(i_periph_dir_in),
    .o_analog_mask(o_analog_mask), .o_port_change_flag(o_port_change_flag),
    .o_wake(o_wake)
);

// File: tb/tpg_pin_model.sv
`timescale 1ns/100ps
// ========================================
// Board side of one port: keys, pull-ups, floating pins
module tpg_pin_model
#(
    parameter W = 8
)
(
    // Clock and pin controls
    input wire i_ref_clk,
    input wire [W-1:0] i_oe,
    input wire [W-1:0] i_out,
    input wire [W-1:0] i_pull,
    input wire [W-1:0] i_ext_en,
    input wire [W-1:0] i_ext_val,
    // Resolved levels
    output reg [W-1:0] o_level
);
    integer k;
    initial o_level = {W{1'b0}};
    // Floating pins toggle, so a stale level is never mistaken for data
    always @(posedge i_ref_clk)
    begin
        for (k = 0; k < W; k = k + 1)
        begin
            if (i_oe[k])
                o_level[k] <= i_out[k]; // Block drives
            else if (i_ext_en[k])
                o_level[k] <= i_ext_val[k]; // Key drives
            else if (i_pull[k])
                o_level[k] <= 1'b1; // Weak pull-up
            else
                o_level[k] <= ~o_level[k];
        end
    end
endmodule // tpg_pin_model
